// *** src/recorder_pkg.sv ***
// Shared constants and types for the recorder control front end and its controller
package recorder_pkg;

  // Master clock frequency and sampling rate divisors
  localparam int unsigned MCLK_HZ          = 50_000_000;
  localparam int unsigned RATE_DIV_LO      = 768;
  localparam int unsigned RATE_DIV_HI      = 512;
  localparam int unsigned RATE_CNT_W       = 10;

  // Host-side strobe width
  localparam int unsigned STROBE_TIME_NS   = 40_000;
  localparam int unsigned STROBE_CYCLES    = (STROBE_TIME_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STROBE_CNT_W     = 12;

  // Word count selection
  localparam logic [1:0] WSEL_EIGHT        = 2'b00;
  localparam logic [1:0] WSEL_FOUR         = 2'b01;
  localparam logic [1:0] WSEL_TWO          = 2'b10;
  localparam logic [1:0] WSEL_FLEX         = 2'b11;
  localparam logic [3:0] WORDS_EIGHT       = 4'h8;
  localparam logic [3:0] WORDS_FOUR        = 4'h4;
  localparam logic [3:0] WORDS_TWO         = 4'h2;
  localparam logic [3:0] WORDS_FLEX        = 4'h1;

  // Nibble commands accepted in microcontroller mode
  localparam logic [3:0] CMD_START_REC     = 4'h1;
  localparam logic [3:0] CMD_START_PLAY    = 4'h2;
  localparam logic [3:0] CMD_HALT          = 4'h3;
  localparam logic [3:0] CMD_PAUSE         = 4'h4;
  localparam logic [3:0] CMD_OUTSIDE_REC   = 4'h5;
  localparam logic [3:0] CMD_OUTSIDE_PLAY  = 4'h6;

  // Idle level of the shared data lines when nobody drives them
  localparam logic [3:0] DQ_IDLE           = 4'hF;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ARMED = 2'b01,
    OP_RUN   = 2'b10,
    OP_PAUSE = 2'b11
  } op_state_e;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_WRITE = 2'b01,
    HS_READ  = 2'b10
  } host_state_e;

endpackage

// *** src/recorder_link_if.sv ***
// Pin-level link between the recorder front end and its controlling party
`timescale 1ns/1ps
interface recorder_link_if;
  import recorder_pkg::*;

  logic       capture_or_replay_select;
  logic       begin_pulse_n;
  logic       halt_pulse_n;
  logic       pause_n;
  logic       word_count_select_hi;
  logic       word_count_select_lo;
  logic       channel_pick_bit0;
  logic       channel_pick_bit1;
  logic       channel_pick_bit2;
  logic       rate_select;
  logic       sleep_policy;
  logic       voice_trigger_enable;
  logic       factory_check_hi;
  logic       factory_check_n;
  logic       chip_select_n;
  logic       host_store_pulse_n;
  logic       read_strobe_n;
  logic [3:0] host_dq_out;
  logic       host_dq_oe_n;
  logic [3:0] dev_dq_out;
  logic       dev_dq_oe_n;
  logic       activity_indicator;
  logic [3:0] dq_level;

  // Resolved level of the shared data lines
  assign dq_level = !dev_dq_oe_n  ? dev_dq_out  :
                    !host_dq_oe_n ? host_dq_out : DQ_IDLE;

  modport device (
    input  capture_or_replay_select, begin_pulse_n, halt_pulse_n, pause_n,
    input  word_count_select_hi, word_count_select_lo,
    input  channel_pick_bit0, channel_pick_bit1, channel_pick_bit2,
    input  rate_select, sleep_policy, voice_trigger_enable,
    input  factory_check_hi, factory_check_n,
    input  chip_select_n, host_store_pulse_n, read_strobe_n, dq_level,
    output dev_dq_out, dev_dq_oe_n, activity_indicator
  );

  modport controller (
    output capture_or_replay_select, begin_pulse_n, halt_pulse_n, pause_n,
    output word_count_select_hi, word_count_select_lo,
    output channel_pick_bit0, channel_pick_bit1, channel_pick_bit2,
    output rate_select, sleep_policy, voice_trigger_enable,
    output factory_check_hi, factory_check_n,
    output chip_select_n, host_store_pulse_n, read_strobe_n,
    output host_dq_out, host_dq_oe_n,
    input  dq_level, activity_indicator
  );
endinterface

// *** src/recorder_device.sv ***
// Recorder control front end: pin and nibble-bus control, run state, rate and power policy
// Operation
// - High select records, low select plays back
// - Low begin pulse starts selected operation
// - Low halt pulse ends current operation
// - Low pause pulse suspends current operation
// - Two selects give 8/4/2 words or flex
// - Stand-alone channel comes from three pick pins
// - Rate select picks one of two divisors
// - Low sleep policy: idle means power-down
// - High sleep policy: idle means standby
// - Reset still forces power-down under high policy
// - Voice trigger delays stand-alone recording until loud input
// - Four-line shared bus, device drives reads
// - Store pulse delivers nibble to device
// - Read pulse makes device drive status
// - Chip select high blocks store and read strobes and bus
// - Activity indicator high while a non-outside operation runs
// - Outside-driven runs emit sync clock pulses
// - Factory check pins tied inactive outside
`timescale 1ns/1ps
module recorder_device
  import recorder_pkg::*;
#(
  parameter int unsigned DIV_LO = RATE_DIV_LO,
  parameter int unsigned DIV_HI = RATE_DIV_HI
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       micro_strap,
  input  wire logic       voice_above_threshold,
  recorder_link_if.device link,
  output logic            recording,
  output logic            playing,
  output logic            paused,
  output logic            power_down,
  output logic            standby,
  output logic            sample_tick,
  output logic [3:0]      word_limit,
  output logic            flex_mode,
  output logic [2:0]      channel
);

  function automatic logic [3:0] words_for(input logic [1:0] sel);
    case (sel)
      WSEL_EIGHT: words_for = WORDS_EIGHT;
      WSEL_FOUR:  words_for = WORDS_FOUR;
      WSEL_TWO:   words_for = WORDS_TWO;
      default:    words_for = WORDS_FLEX;
    endcase
  endfunction

  op_state_e              state_q;
  logic                   micro_q;
  logic                   begin_prev_q;
  logic                   halt_prev_q;
  logic                   pause_prev_q;
  logic                   store_prev_q;
  logic                   record_q;
  logic                   outside_q;
  logic                   power_down_q;
  logic [RATE_CNT_W-1:0]  rate_cnt_q;
  logic                   tick_q;
  logic                   sync_clk_q;
  logic                   activity_q;
  logic [3:0]             status_q;
  logic [3:0]             word_limit_q;
  logic                   flex_q;
  logic [2:0]             channel_q;

  logic                   sa;
  logic                   store_ev;
  logic [3:0]             cmd;
  logic                   begin_ev;
  logic                   halt_ev;
  logic                   pause_ev;
  logic                   dir_rec;
  logic                   outside_start;
  logic [RATE_CNT_W-1:0]  div_last;

  assign sa = !micro_q;

  // A nibble counts only when the chip is selected at the store edge
  assign store_ev = micro_q && store_prev_q && !link.host_store_pulse_n
                    && !link.chip_select_n;
  assign cmd      = link.dq_level;

  // Edge detect so a held-low pin acts once
  always_comb begin
    begin_ev  = 1'b0;
    halt_ev   = 1'b0;
    pause_ev  = 1'b0;
    dir_rec   = record_q;
    outside_start = 1'b0;
    if (sa) begin
      begin_ev = begin_prev_q && !link.begin_pulse_n;
      halt_ev  = halt_prev_q && !link.halt_pulse_n;
      pause_ev = pause_prev_q && !link.pause_n;
      dir_rec  = link.capture_or_replay_select;
    end else if (store_ev) begin
      case (cmd)
        CMD_START_REC: begin
          begin_ev = 1'b1;
          dir_rec  = 1'b1;
        end
        CMD_START_PLAY: begin
          begin_ev = 1'b1;
          dir_rec  = 1'b0;
        end
        CMD_OUTSIDE_REC: begin
          begin_ev      = 1'b1;
          dir_rec       = 1'b1;
          outside_start = 1'b1;
        end
        CMD_OUTSIDE_PLAY: begin
          begin_ev      = 1'b1;
          dir_rec       = 1'b0;
          outside_start = 1'b1;
        end
        CMD_HALT:  halt_ev  = 1'b1;
        CMD_PAUSE: pause_ev = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // Mode strap is caught by the clocked reset, so the pin roles never change mid-run
  always_ff @(posedge mclk) begin
    if (reset) begin
      micro_q <= micro_strap;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      begin_prev_q <= 1'b1;
      halt_prev_q  <= 1'b1;
      pause_prev_q <= 1'b1;
      store_prev_q <= 1'b1;
    end else if (ce) begin
      begin_prev_q <= link.begin_pulse_n;
      halt_prev_q  <= link.halt_pulse_n;
      pause_prev_q <= link.pause_n;
      store_prev_q <= link.host_store_pulse_n;
    end
  end

  // Halt outranks start, start outranks pause except in run, where start is ignored and pause acts; start also resumes a pause
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q   <= OP_IDLE;
      record_q  <= 1'b0;
      outside_q <= 1'b0;
    end else if (ce) begin
      if (halt_ev) begin
        state_q   <= OP_IDLE;
        outside_q <= 1'b0;
      end else if (begin_ev && state_q == OP_PAUSE) begin
        state_q <= OP_RUN;
      end else if (begin_ev && state_q == OP_IDLE) begin
        record_q  <= dir_rec;
        outside_q <= outside_start;
        if (dir_rec && sa && link.voice_trigger_enable) begin
          state_q <= OP_ARMED;
        end else begin
          state_q <= OP_RUN;
        end
      end else if (state_q == OP_ARMED && voice_above_threshold) begin
        state_q <= OP_RUN;
      end else if (pause_ev && state_q == OP_RUN) begin
        state_q <= OP_PAUSE;
      end
    end
  end

  // Word count, and in stand-alone mode the channel, are captured at start so a run keeps its setup
  always_ff @(posedge mclk) begin
    if (reset) begin
      word_limit_q <= WORDS_EIGHT;
      flex_q       <= 1'b0;
      channel_q    <= 3'h0;
    end else if (ce && begin_ev && state_q == OP_IDLE) begin
      word_limit_q <= words_for({link.word_count_select_hi,
                                 link.word_count_select_lo});
      flex_q       <= ({link.word_count_select_hi,
                        link.word_count_select_lo} == WSEL_FLEX);
      if (sa) begin
        channel_q <= {link.channel_pick_bit2, link.channel_pick_bit1,
                      link.channel_pick_bit0};
      end
    end
  end

  // Fixed division of mclk; counter is cleared to zero while idle to save power
  assign div_last = rate_select_last(link.rate_select);

  function automatic logic [RATE_CNT_W-1:0] rate_select_last(input logic hi);
    rate_select_last = hi ? RATE_CNT_W'(DIV_HI - 1) : RATE_CNT_W'(DIV_LO - 1);
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      rate_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (state_q == OP_IDLE) begin
        rate_cnt_q <= '0;
      end else if (rate_cnt_q >= div_last) begin
        rate_cnt_q <= '0;
        tick_q     <= 1'b1;
      end else begin
        rate_cnt_q <= rate_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_clk_q <= 1'b0;
      activity_q <= 1'b0;
    end else if (ce) begin
      if (state_q == OP_IDLE || !outside_q) begin
        sync_clk_q <= 1'b0;
      end else if (tick_q) begin
        sync_clk_q <= !sync_clk_q;
      end
      if (state_q == OP_RUN || state_q == OP_PAUSE) begin
        activity_q <= outside_q ? sync_clk_q : 1'b1;
      end else begin
        activity_q <= 1'b0;
      end
    end
  end

  // Reset always lands in power-down, whatever the policy
  always_ff @(posedge mclk) begin
    if (reset) begin
      power_down_q <= 1'b1;
    end else if (ce) begin
      if (state_q != OP_IDLE || begin_ev) begin
        power_down_q <= 1'b0;
      end else if (!link.sleep_policy) begin
        power_down_q <= 1'b1;
      end else if (halt_ev) begin
        power_down_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      status_q <= 4'h0;
    end else if (ce) begin
      status_q <= {outside_q, state_q == OP_PAUSE,
                   state_q == OP_RUN || state_q == OP_ARMED, record_q};
    end
  end

  // Device drives the lines only inside a selected read pulse
  assign link.dev_dq_oe_n = !(micro_q && !link.chip_select_n
                              && !link.read_strobe_n);
  assign link.dev_dq_out  = status_q;
  assign link.activity_indicator = activity_q;

  assign recording   = record_q && state_q == OP_RUN;
  assign playing     = !record_q && state_q == OP_RUN;
  assign paused      = state_q == OP_PAUSE;
  assign power_down  = power_down_q && state_q == OP_IDLE;
  assign standby     = !power_down_q && state_q == OP_IDLE;
  assign sample_tick = tick_q;
  assign word_limit  = word_limit_q;
  assign flex_mode   = flex_q;
  assign channel     = channel_q;

endmodule // recorder_device

// *** src/recorder_controller.sv ***
// Controlling party: drives level pins and strobes, runs nibble writes and reads
`timescale 1ns/1ps
module recorder_controller
  import recorder_pkg::*;
#(
  parameter int unsigned STROBE_LEN = STROBE_CYCLES
) (
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           ce,
  recorder_link_if.controller link,
  input  wire logic           cfg_record,
  input  wire logic [1:0]     cfg_word_select,
  input  wire logic [2:0]     cfg_channel,
  input  wire logic           cfg_rate_hi,
  input  wire logic           cfg_sleep_policy,
  input  wire logic           cfg_voice_trigger,
  input  wire logic           req_begin,
  input  wire logic           req_halt,
  input  wire logic           req_pause,
  input  wire logic           wr_valid,
  input  wire logic [3:0]     wr_nibble,
  input  wire logic           rd_req,
  output logic                busy,
  output logic                rd_valid,
  output logic [3:0]          rd_nibble,
  output logic                active
);

  host_state_e             hs_q;
  logic [STROBE_CNT_W-1:0] cnt_q;
  logic [2:0]              pulse_q;
  logic [3:0]              wr_q;
  logic [3:0]              rd_q;
  logic                    rd_valid_q;
  logic [5:0]              cfg_q;
  logic [2:0]              chan_q;
  logic                    last;

  assign last = (cnt_q == STROBE_CNT_W'(STROBE_LEN - 1));

  // One cycle at a time, but begin/halt/pause requests in one cycle pulse their pins together; pin pulses and bus cycles share the same timer
  always_ff @(posedge mclk) begin
    if (reset) begin
      hs_q       <= HS_IDLE;
      cnt_q      <= '0;
      pulse_q    <= 3'b000;
      wr_q       <= 4'h0;
      rd_q       <= 4'h0;
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= 1'b0;
      case (hs_q)
        HS_IDLE: begin
          cnt_q <= '0;
          if (req_halt || req_begin || req_pause) begin
            pulse_q <= {req_pause, req_halt, req_begin};
            hs_q    <= HS_WRITE;
          end else if (wr_valid) begin
            wr_q <= wr_nibble;
            hs_q <= HS_WRITE;
          end else if (rd_req) begin
            hs_q <= HS_READ;
          end
        end
        default: begin
          cnt_q <= cnt_q + 1'b1;
          if (last) begin
            if (hs_q == HS_READ) begin
              rd_q       <= link.dq_level;
              rd_valid_q <= 1'b1;
            end
            pulse_q <= 3'b000;
            hs_q    <= HS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q  <= 6'h0;
      chan_q <= 3'h0;
    end else if (ce) begin
      cfg_q  <= {cfg_record, cfg_word_select, cfg_rate_hi, cfg_sleep_policy,
                 cfg_voice_trigger};
      chan_q <= cfg_channel;
    end
  end

  // Pulse requests use the stand-alone pins, plain writes use the store strobe
  assign link.begin_pulse_n      = !(hs_q == HS_WRITE && pulse_q[0]);
  assign link.halt_pulse_n       = !(hs_q == HS_WRITE && pulse_q[1]);
  assign link.pause_n            = !(hs_q == HS_WRITE && pulse_q[2]);
  assign link.host_store_pulse_n = !(hs_q == HS_WRITE && pulse_q == 3'b000);
  assign link.read_strobe_n      = !(hs_q == HS_READ);
  assign link.chip_select_n      = (hs_q == HS_IDLE);
  assign link.host_dq_oe_n       = !(hs_q == HS_WRITE && pulse_q == 3'b000);
  assign link.host_dq_out        = wr_q;

  assign link.capture_or_replay_select = cfg_q[5];
  assign link.word_count_select_hi     = cfg_q[4];
  assign link.word_count_select_lo     = cfg_q[3];
  assign link.rate_select              = cfg_q[2];
  assign link.sleep_policy             = cfg_q[1];
  assign link.voice_trigger_enable     = cfg_q[0];
  assign link.channel_pick_bit0        = chan_q[0];
  assign link.channel_pick_bit1        = chan_q[1];
  assign link.channel_pick_bit2        = chan_q[2];

  // Factory test pins held inactive
  assign link.factory_check_hi = 1'b0;
  assign link.factory_check_n  = 1'b1;

  assign busy      = (hs_q != HS_IDLE);
  assign rd_valid  = rd_valid_q;
  assign rd_nibble = rd_q;
  assign active    = link.activity_indicator;

endmodule // recorder_controller

// *** tb/recorder_link_props.sv ***
// Concurrent checks on the pin link between the two recorder ends
`timescale 1ns/1ps
module recorder_link_props
  import recorder_pkg::*;
#(
  parameter int unsigned STROBE_LEN = STROBE_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic begin_pulse_n,
  input wire logic halt_pulse_n,
  input wire logic pause_n,
  input wire logic voice_trigger_enable,
  input wire logic factory_check_hi,
  input wire logic factory_check_n,
  input wire logic chip_select_n,
  input wire logic host_store_pulse_n,
  input wire logic read_strobe_n,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic activity_indicator
);
  logic        all_hi;
  logic [11:0] low_cnt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Any strobe low counts; the controller overlaps strobes only for begin, halt and pause requests made in the same cycle
  assign all_hi = begin_pulse_n & halt_pulse_n & pause_n & host_store_pulse_n & read_strobe_n;

  always_ff @(posedge mclk) begin
    if (reset || all_hi) begin
      low_cnt_q <= 12'h000;
    end else begin
      low_cnt_q <= low_cnt_q + 12'h001;
    end
  end

  reset_quiet_a: assert property ($fell(reset) |-> !activity_indicator && dev_dq_oe_n)
    else $error("activity or bus drive left on by reset");
  begin_active_a: assert property (
    $fell(begin_pulse_n) && halt_pulse_n && !voice_trigger_enable && !activity_indicator
    |-> ##[1:3] activity_indicator)
    else $error("begin pulse did not raise activity");
  halt_idle_a: assert property ($fell(halt_pulse_n) |-> ##[1:3] !activity_indicator)
    else $error("halt pulse did not end activity");
  pause_hold_a: assert property (
    $fell(pause_n) && activity_indicator |-> activity_indicator [*4])
    else $error("activity dropped while paused");
  strobe_len_a: assert property ($rose(all_hi) |-> low_cnt_q == STROBE_LEN)
    else $error("strobe low time differs from setting");
  strobe_cs_a: assert property (!host_store_pulse_n || !read_strobe_n |-> !chip_select_n)
    else $error("bus strobe without chip select");
  host_release_a: assert property (!read_strobe_n |-> host_dq_oe_n)
    else $error("host drives the bus during a read");
  store_drive_a: assert property (!host_store_pulse_n |-> !host_dq_oe_n)
    else $error("store strobe without host data");
  dev_drive_a: assert property (!dev_dq_oe_n |-> !chip_select_n && !read_strobe_n)
    else $error("device drives bus outside a selected read");
  factory_tie_a: assert property (!factory_check_hi && factory_check_n)
    else $error("factory check pins not at inactive levels");

  cover property ($fell(begin_pulse_n));
  cover property ($fell(pause_n) && activity_indicator);
  cover property (!dev_dq_oe_n);
  cover property ($fell(host_store_pulse_n));
endmodule // recorder_link_props

// *** tb/voice_recorder_control_front_end_tb.sv ***
// Self-checking bench joining the recorder front end to its controller
`timescale 1ns/1ps
module voice_recorder_control_front_end_tb;
  import recorder_pkg::*;
  localparam int unsigned SLEN = 3;
  localparam int unsigned DLO  = 8;
  localparam int unsigned DHI  = 4;
  logic       mclk;
  logic       reset;
  logic       micro_strap;
  logic       voice_above;
  logic       cfg_record;
  logic [1:0] cfg_word_select;
  logic [2:0] cfg_channel;
  logic       cfg_rate_hi;
  logic       cfg_sleep;
  logic       cfg_voice;
  logic [4:0] req;
  logic [3:0] wr_nibble;
  logic       recording;
  logic       playing;
  logic       paused;
  logic       power_down;
  logic       standby;
  logic       sample_tick;
  logic [3:0] word_limit;
  logic       flex_mode;
  logic [2:0] channel;
  logic       busy;
  logic       rd_valid;
  logic [3:0] rd_nibble;
  logic       active;
  int         num_errors = 0;
  int         num_checks = 0;

  recorder_link_if recorder_link_if_inst ();

  recorder_device #(.DIV_LO(DLO), .DIV_HI(DHI)) recorder_device_inst (
    .mclk(mclk), .reset(reset), .ce(1'b1), .micro_strap(micro_strap),
    .voice_above_threshold(voice_above), .link(recorder_link_if_inst),
    .recording(recording), .playing(playing), .paused(paused), .power_down(power_down),
    .standby(standby), .sample_tick(sample_tick), .word_limit(word_limit),
    .flex_mode(flex_mode), .channel(channel));

  recorder_controller #(.STROBE_LEN(SLEN)) recorder_controller_inst (
    .mclk(mclk), .reset(reset), .ce(1'b1), .link(recorder_link_if_inst),
    .cfg_record(cfg_record), .cfg_word_select(cfg_word_select), .cfg_channel(cfg_channel),
    .cfg_rate_hi(cfg_rate_hi), .cfg_sleep_policy(cfg_sleep), .cfg_voice_trigger(cfg_voice),
    .req_begin(req[0]), .req_halt(req[1]), .req_pause(req[2]), .wr_valid(req[3]),
    .wr_nibble(wr_nibble), .rd_req(req[4]), .busy(busy), .rd_valid(rd_valid),
    .rd_nibble(rd_nibble), .active(active));

  recorder_link_props #(.STROBE_LEN(SLEN)) recorder_link_props_inst (
    .mclk(mclk), .reset(reset),
    .begin_pulse_n(recorder_link_if_inst.begin_pulse_n),
    .halt_pulse_n(recorder_link_if_inst.halt_pulse_n),
    .pause_n(recorder_link_if_inst.pause_n),
    .voice_trigger_enable(recorder_link_if_inst.voice_trigger_enable),
    .factory_check_hi(recorder_link_if_inst.factory_check_hi),
    .factory_check_n(recorder_link_if_inst.factory_check_n),
    .chip_select_n(recorder_link_if_inst.chip_select_n),
    .host_store_pulse_n(recorder_link_if_inst.host_store_pulse_n),
    .read_strobe_n(recorder_link_if_inst.read_strobe_n),
    .host_dq_oe_n(recorder_link_if_inst.host_dq_oe_n),
    .dev_dq_oe_n(recorder_link_if_inst.dev_dq_oe_n),
    .activity_indicator(recorder_link_if_inst.activity_indicator));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  // Codes 0..4: begin, halt, pause, nibble write, nibble read
  task automatic op(input int k, input logic [3:0] nib);
    int n;
    repeat (3) @(posedge mclk);
    wr_nibble <= nib;
    req[k] <= 1'b1;
    @(posedge mclk);
    req <= 5'h00;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      #1;
      if (!busy) break;
    end
    if (n == 40) begin
      num_errors++;
      $display("FAIL controller_busy expected 0 seen 1");
      close_out();
    end
    if (k == 4) begin
      chk("rd_valid", rd_valid, 1'b1);
    end
    // Device state settles two cycles after the pin edge
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge mclk);
    reset <= 1'b1;
    micro_strap <= strap;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic t_words();
    logic [3:0] lim [4] = '{WORDS_EIGHT, WORDS_FOUR, WORDS_TWO, WORDS_FLEX};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      cfg_word_select <= 2'(i);
      cfg_channel <= 3'(7 - 2 * i);
      // Word count and channel are latched only when a run starts
      op(0, 4'h0);
      chk("word_limit", word_limit, lim[i]);
      chk("flex_mode", flex_mode, (i == 3));
      chk("channel", channel, 4'(7 - 2 * i));
      op(1, 4'h0);
    end
    $display("test words done");
  endtask

  task automatic t_record();
    int n;
    chk("reset_power_down", {active, power_down}, 4'h1);
    @(posedge mclk);
    cfg_record <= 1'b1;
    op(0, 4'h0);
    chk("rec_state", {recording, playing, active, power_down}, 4'hA);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      cfg_rate_hi <= k[0];
      repeat (20) @(posedge mclk);
      #1;
      // Sample after the edge so the tick that edge launches is seen
      for (n = 0; n < 40 && sample_tick !== 1'b1; n++) begin
        @(posedge mclk);
        #1;
      end
      for (n = 1; n < 40; n++) begin
        @(posedge mclk);
        #1;
        if (sample_tick === 1'b1) break;
      end
      chk("tick_period", n == (k ? DHI : DLO), 1'b1);
    end
    op(2, 4'h0);
    chk("paused", {paused, active}, 4'h3);
    op(0, 4'h0);
    chk("resumed", {paused, recording}, 4'h1);
    op(0, 4'h0);
    chk("begin_while_run", recording, 1'b1);
    op(1, 4'h0);
    chk("rec_halted", {recording, active, power_down, standby}, 4'h2);
    $display("test record done");
  endtask

  task automatic t_play();
    @(posedge mclk);
    cfg_record <= 1'b0;
    cfg_sleep <= 1'b1;
    op(0, 4'h0);
    chk("play_state", {recording, playing, active}, 4'h3);
    op(1, 4'h0);
    chk("standby", {power_down, standby, active}, 4'h2);
    do_reset(1'b0);
    chk("reset_sleep", {power_down, standby}, 4'h2);
    $display("test play done");
  endtask

  task automatic t_voice();
    @(posedge mclk);
    cfg_sleep <= 1'b0;
    cfg_record <= 1'b1;
    cfg_voice <= 1'b1;
    op(0, 4'h0);
    chk("armed_quiet", recording, 1'b0);
    @(posedge mclk);
    voice_above <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("voice_start", recording, 1'b1);
    op(1, 4'h0);
    voice_above <= 1'b0;
    cfg_voice <= 1'b0;
    $display("test voice done");
  endtask

  task automatic t_micro();
    int t;
    logic prev;
    do_reset(1'b1);
    op(3, CMD_START_REC);
    chk("cmd_rec", {recording, active}, 4'h3);
    op(4, 4'h0);
    chk("status_rec", rd_nibble, 4'h3);
    op(3, CMD_HALT);
    chk("cmd_halt", recording, 1'b0);
    op(3, 4'hF);
    chk("cmd_unknown", {recording, playing}, 4'h0);
    op(3, CMD_OUTSIDE_PLAY);
    // A steady high shows no edges; sync pulses toggle once per sample tick
    t = 0;
    for (int i = 0; i < 40; i++) begin
      prev = active;
      @(posedge mclk);
      #1;
      if (active !== prev) t++;
    end
    chk("outside_sync_toggles", t >= 2, 1'b1);
    op(4, 4'h0);
    chk("status_outside", {rd_nibble[3], rd_nibble[0]}, 4'h2);
    op(3, CMD_HALT);
    chk("outside_halted", playing, 1'b0);
    $display("test micro done");
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    reset = 1'b1;
    micro_strap = 1'b0;
    voice_above = 1'b0;
    cfg_record = 1'b0;
    cfg_word_select = 2'b00;
    cfg_channel = 3'b000;
    cfg_rate_hi = 1'b0;
    cfg_sleep = 1'b0;
    cfg_voice = 1'b0;
    req = 5'h00;
    wr_nibble = 4'h0;
    do_reset(1'b0);
    t_words();
    t_record();
    t_play();
    t_voice();
    t_micro();
    close_out();
  end
endmodule // voice_recorder_control_front_end_tb
